// *** feih_top.v ***
// fault event interrupt handler: sticky fault flags, masks, live
// status, driver-enable and warm reset control, wishbone slave.
// assumes classic wishbone master on clk_i; pins are asynchronous.
//
// Overview of operation
// - proc reset readback low: flag only, live
// - monitor pin fault sets maskable pin flag
// - write one ignored while fault persists
// - fault past first delay: fail flag, driver off
// - fail flag maskable, clear needs fault gone
// - past both delays: reset flag, warm reset
// - reset flag readable after warm reset done
// - missing external clock sets clock fault flag
// - watchdog fail over limit: flag, driver off
// - watchdog over reset limit: flag, warm reset
// - watchdog reset flag readable after recovery
`timescale 1ns/1ps
`include "feih_consts.vh"
module feih_top
#(
  parameter RECOVERY_LIMIT = 4'h2  // most warm resets tolerated
)
(
  input  wire        clk_i,                   // core clock, 10 mhz
  input  wire        rst_i,                   // synchronous reset
  input  wire        cyc_i,                   // wishbone cycle
  input  wire        stb_i,                   // wishbone strobe
  input  wire        we_i,                    // wishbone write
  input  wire [7:0]  adr_i,                   // wishbone byte address
  input  wire [3:0]  sel_i,                   // wishbone byte selects
  input  wire [31:0] dat_i,                   // wishbone write data
  output reg  [31:0] dat_o,                   // wishbone read data
  output reg         ack_o,                   // wishbone acknowledge
  input  wire        proc_reset_readback_i,   // processor reset pin level
  input  wire        error_monitor_i,         // error signal from controller
  input  wire        ext_clk_bad_i,           // switching clock out of range
  input  wire [3:0]  watchdog_fail_count_i,   // watchdog fail counter
  input  wire [3:0]  recovery_count_i,        // warm reset recovery counter
  output reg         driver_enable_output_o,  // driver enable pin
  output reg         controller_reset_output_n_o, // controller reset, low active
  output reg         processor_reset_output_n_o,  // processor reset, low active
  output reg         interrupt_output_low_n_o,    // fault interrupt, low active
  output reg         irq_o                    // summary interrupt, high active
);
  // one-hot warm reset states
  localparam [2:0] ST_RUN  = 3'b001;  // normal operation
  localparam [2:0] ST_WARM = 3'b010;  // reset outputs asserted
  localparam [2:0] ST_DONE = 3'b100;  // one cycle after release

  wire [6:0] flag;             // sticky flags
  reg  [6:0] mask;             // per-flag masks
  reg  [3:0] cfg;              // configuration bits
  reg  [7:0] first_delay;      // first delay in ticks
  reg  [7:0] second_delay;     // second delay in ticks
  reg  [3:0] watchdog_fail_limit;  // watchdog fail limit
  reg  [3:0] watchdog_reset_limit; // watchdog reset limit
  reg  [6:0] irq_stat;         // bus interrupt status, clear on read
  reg  [6:0] irq_mask;         // bus interrupt mask
  reg  [6:0] flag_d;           // previous flags for rise detection
  reg  [2:0] state;            // warm reset state
  reg  [4:0] warm_cnt;         // warm reset pulse counter
  reg  [3:0] tick_cnt;         // delay tick prescaler
  reg  [8:0] fault_ticks;      // ticks the monitor fault has lasted
  reg        em_pwm_d;         // pwm mode edge tracking
  reg  [7:0] pwm_cnt;          // cycles since last pwm edge
  reg  [7:0] em_err_cnt;       // pwm error counter
  reg  [6:0] vis;              // flags visible to software
  reg  [6:0] clr;              // write-one clear strobes
  wire       proc_rb;          // synchronised readback level
  wire       em_lvl;           // synchronised error signal
  wire       clk_bad;          // synchronised clock fault
  wire       proc_rb_n;        // inverted readback level, idles low
  wire       em_lvl_n;         // inverted error signal, idles low
  wire [6:0] hold;             // per-flag condition that refuses a clear
  wire       req;              // valid bus request
  wire       tick;             // one delay tick
  wire       em_bad;           // monitor pin fault now
  wire       em_fail_cond;     // fault longer than the first delay
  wire       em_rst_cond;      // fault longer than both delays
  wire       wd_fail_cond;     // watchdog count above fail limit
  wire       watchdog_reset_trigger_cond;      // watchdog count above reset limit
  wire [6:0] live;             // live status
  wire [6:0] cause;            // per-flag underlying cause

  // pin synchronisers
  // pins that idle high pass the chain inverted, so the chain's reset
  // level equals the idle level and no false fault follows reset
  feih_sync u_sync_rb (.clk_i(clk_i), .rst_i(rst_i), .d_i(~proc_reset_readback_i),
                       .q_o(proc_rb_n));
  feih_sync u_sync_em (.clk_i(clk_i), .rst_i(rst_i), .d_i(~error_monitor_i),
                       .q_o(em_lvl_n));
  assign proc_rb = ~proc_rb_n;
  assign em_lvl  = ~em_lvl_n;
  feih_sync u_sync_ck (.clk_i(clk_i), .rst_i(rst_i), .d_i(ext_clk_bad_i),
                       .q_o(clk_bad));

  assign req  = cyc_i && stb_i && !ack_o;
  assign tick = ({28'h0000000, tick_cnt} == (`FEIH_TICK_CYC - 1));

  // pin timing: edge spacing past the pwm_cnt timeout counts as pwm error
  wire pwm_viol = cfg[`FEIH_C_EM_PWM] && (pwm_cnt == 8'hff);
  // pin fault: low level, or pwm timing violation
  assign em_bad = cfg[`FEIH_C_EM_PWM] ? pwm_viol : !em_lvl;
  // persisting fault: low level, or error count over limit in pwm mode
  wire em_persist = cfg[`FEIH_C_EM_PWM] ? (em_err_cnt > {4'h0, watchdog_fail_limit})
                                        : !em_lvl;
  assign em_fail_cond = em_persist && (fault_ticks > {1'b0, first_delay});
  assign em_rst_cond  = em_persist &&
                        (fault_ticks > ({1'b0, first_delay} + {1'b0, second_delay}));
  assign wd_fail_cond = watchdog_fail_count_i > watchdog_fail_limit;
  assign watchdog_reset_trigger_cond  = watchdog_fail_count_i > watchdog_reset_limit;

  // readback error: pin low while it should be high
  wire proc_rb_bad = processor_reset_output_n_o && !proc_rb;
  wire clk_fault   = cfg[`FEIH_C_CLK_EXP] && clk_bad;

  assign live = {1'b0, 1'b0, clk_fault, 1'b0, 1'b0, 1'b0, proc_rb_bad};
  assign cause = {watchdog_reset_trigger_cond, wd_fail_cond, clk_fault, em_rst_cond,
                  em_fail_cond, em_bad, proc_rb_bad};
  // watchdog fail flag stays until the count is below the limit
  assign hold = {cause[6], (watchdog_fail_count_i >= watchdog_fail_limit),
                 cause[4:0]};

  // one sticky flag per event
  genvar gi;
  generate
    for (gi = 0; gi < `FEIH_NFLAGS; gi = gi + 1)
    begin : g_flag
      feih_flag u_flag (.clk_i(clk_i), .rst_i(rst_i), .set_i(cause[gi]),
                        .cause_i(hold[gi]), .clr_i(clr[gi]), .flag_o(flag[gi]));
    end
  endgenerate

  // write-one clear strobes on the flag register
  always @*
  begin
    clr = 7'h00;
    if (req && we_i && sel_i[0] && adr_i == `FEIH_FLAG_ADDR)
      clr = dat_i[6:0];
  end

  // reset flags hidden until warm reset done and recovery in range
  always @*
  begin
    vis = flag;
    if (state != ST_RUN || recovery_count_i > RECOVERY_LIMIT)
    begin
      vis[`FEIH_B_EM_RST] = 1'b0;
      vis[`FEIH_B_WDOG_RESET] = 1'b0;
    end
  end

  // delay prescaler and fault duration counter
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt    <= 4'h0;
      fault_ticks <= 9'h000;
    end
    else
    begin
      tick_cnt <= tick ? 4'h0 : tick_cnt + 4'h1;
      if (!em_persist)
        fault_ticks <= 9'h000;
      else if (tick && fault_ticks != 9'h1ff)
        fault_ticks <= fault_ticks + 9'h001;
    end
  end

  // pwm mode: count cycles between edges, errors on timeout
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      em_pwm_d   <= 1'b1;  // idle level, so no false edge after reset
      pwm_cnt    <= 8'h00;
      em_err_cnt <= 8'h00;
    end
    else
    begin
      em_pwm_d <= em_lvl;
      if (em_pwm_d != em_lvl)
      begin
        pwm_cnt <= 8'h00;
        if (em_err_cnt != 8'h00)
          em_err_cnt <= em_err_cnt - 8'h01;
      end
      else if (pwm_cnt != 8'hff)
        pwm_cnt <= pwm_cnt + 8'h01;
      else
      begin
        pwm_cnt <= 8'h00;
        if (em_err_cnt != 8'hff)
          em_err_cnt <= em_err_cnt + 8'h01;
      end
    end
  end

  // warm reset sequencer and output pins
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state                       <= ST_RUN;
      warm_cnt                    <= 5'h00;
      driver_enable_output_o      <= 1'b0;
      controller_reset_output_n_o <= 1'b1;
      processor_reset_output_n_o  <= 1'b1;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          controller_reset_output_n_o <= 1'b1;
          processor_reset_output_n_o  <= 1'b1;
          if (em_rst_cond || (watchdog_reset_trigger_cond && cfg[`FEIH_C_WDOG_RST_ON]))
          begin
            state                       <= ST_WARM;
            warm_cnt                    <= 5'h00;
            driver_enable_output_o      <= 1'b0;
            controller_reset_output_n_o <= 1'b0;
            processor_reset_output_n_o  <= 1'b0;
          end
          else
            driver_enable_output_o <= !(wd_fail_cond || flag[`FEIH_B_WD_FAIL]) &&
                                      !(em_fail_cond && cfg[`FEIH_C_EM_DRV]);
        end
        ST_WARM:
        begin
          driver_enable_output_o <= 1'b0;
          if ({27'h0000000, warm_cnt} == (`FEIH_WARM_CYC - 1))
          begin
            state                       <= ST_DONE;
            controller_reset_output_n_o <= 1'b1;
            processor_reset_output_n_o  <= 1'b1;
          end
          else
            warm_cnt <= warm_cnt + 5'h01;
        end
        ST_DONE:
          state <= ST_RUN;  // back to the current operating state
        default:
          state <= ST_RUN;
      endcase
    end
  end

  // register writes, bus interrupt status and pin interrupt
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask                     <= `FEIH_MASK_RST;
      cfg                      <= `FEIH_CFG_RST;
      first_delay              <= `FEIH_FIRST_DLY_RST;
      second_delay             <= `FEIH_SECOND_DLY_RST;
      watchdog_fail_limit      <= `FEIH_WDFAIL_RST;
      watchdog_reset_limit     <= `FEIH_WDRST_RST;
      irq_stat                 <= 7'h00;
      irq_mask                 <= 7'h00;
      flag_d                   <= 7'h00;
      ack_o                    <= 1'b0;
      dat_o                    <= 32'h0000_0000;
      interrupt_output_low_n_o <= 1'b1;
      irq_o                    <= 1'b0;
    end
    else
    begin
      ack_o  <= req;
      flag_d <= flag;
      // new flag rises set bus status; set wins over read clear
      if (req && !we_i && adr_i == `FEIH_IRQ_ADDR)
        irq_stat <= flag & ~flag_d;
      else
        irq_stat <= irq_stat | (flag & ~flag_d);
      // watchdog flags are unmaskable on the pin
      interrupt_output_low_n_o <= ~|(vis & ~(mask & 7'h1f));
      irq_o <= |(irq_stat & ~irq_mask);
      if (req && we_i)
      begin
        if (adr_i == `FEIH_MASK_ADDR && sel_i[0])
          mask <= dat_i[6:0];
        else if (adr_i == `FEIH_CFG_ADDR && sel_i[0])
          cfg <= dat_i[3:0];
        else if (adr_i == `FEIH_DELAY_ADDR)
        begin
          if (sel_i[0])
            first_delay <= dat_i[7:0];
          if (sel_i[1])
            second_delay <= dat_i[15:8];
        end
        else if (adr_i == `FEIH_WDLIM_ADDR && sel_i[0])
        begin
          watchdog_fail_limit  <= dat_i[3:0];
          watchdog_reset_limit <= dat_i[7:4];
        end
        else if (adr_i == `FEIH_IRQMASK_ADDR && sel_i[0])
          irq_mask <= dat_i[6:0];
      end
      if (req && !we_i)
      begin
        if (adr_i == `FEIH_FLAG_ADDR)
          dat_o <= {25'h0, vis};
        else if (adr_i == `FEIH_MASK_ADDR)
          dat_o <= {25'h0, mask};
        else if (adr_i == `FEIH_LIVE_ADDR)
          dat_o <= {25'h0, live};
        else if (adr_i == `FEIH_CFG_ADDR)
          dat_o <= {28'h0, cfg};
        else if (adr_i == `FEIH_DELAY_ADDR)
          dat_o <= {16'h0, second_delay, first_delay};
        else if (adr_i == `FEIH_WDLIM_ADDR)
          dat_o <= {24'h0, watchdog_reset_limit, watchdog_fail_limit};
        else if (adr_i == `FEIH_IRQ_ADDR)
          dat_o <= {25'h0, irq_stat};
        else if (adr_i == `FEIH_IRQMASK_ADDR)
          dat_o <= {25'h0, irq_mask};
        else
          dat_o <= 32'h0000_0000;  // unmapped reads zero
      end
    end
  end
endmodule // feih_top

// *** feih_consts.vh ***
// register offsets, field positions, reset values and timing counts
// for the fault event interrupt handler; definitions only
`ifndef FEIH_CONSTS_VH
`define FEIH_CONSTS_VH

// register byte offsets on the wishbone slave
`define FEIH_FLAG_ADDR      8'h00
`define FEIH_MASK_ADDR      8'h04
`define FEIH_LIVE_ADDR      8'h08
`define FEIH_CFG_ADDR       8'h0c
`define FEIH_DELAY_ADDR     8'h10
`define FEIH_WDLIM_ADDR     8'h14
`define FEIH_IRQ_ADDR       8'h18
`define FEIH_IRQMASK_ADDR   8'h1c

// flag / mask / live bit positions
`define FEIH_B_PROC_RB      0
`define FEIH_B_EM_PIN       1
`define FEIH_B_EM_FAIL      2
`define FEIH_B_EM_RST       3
`define FEIH_B_CLK          4
`define FEIH_B_WD_FAIL      5
`define FEIH_B_WDOG_RESET   6
`define FEIH_NFLAGS         7

// configuration bit positions
`define FEIH_C_EM_PWM       0
`define FEIH_C_EM_DRV       1
`define FEIH_C_WDOG_RST_ON  2
`define FEIH_C_CLK_EXP      3

// reset values
`define FEIH_MASK_RST       7'h00
`define FEIH_CFG_RST        4'h2
`define FEIH_FIRST_DLY_RST  8'h0a
`define FEIH_SECOND_DLY_RST 8'h0a
`define FEIH_WDFAIL_RST     4'h3
`define FEIH_WDRST_RST      4'h7

// timing: delay unit and warm reset pulse length
`define FEIH_TICK_NS        1000
`define FEIH_CLK_NS         100
`define FEIH_TICK_CYC       ((`FEIH_TICK_NS + `FEIH_CLK_NS - 1) / `FEIH_CLK_NS)
`define FEIH_WARM_NS        2000
`define FEIH_WARM_CYC       ((`FEIH_WARM_NS + `FEIH_CLK_NS - 1) / `FEIH_CLK_NS)

`endif

// *** feih_sync.v ***
// three-flop synchroniser for one pin input; out changes once
// the second and third stages agree, otherwise holds
`timescale 1ns/1ps
module feih_sync
(
  input  wire clk_i,   // core clock
  input  wire rst_i,   // synchronous reset, active high
  input  wire d_i,     // asynchronous pin level
  output reg  q_o      // filtered level
);
  reg s1;  // first stage, read only by s2
  reg s2;  // second stage
  reg s3;  // third stage

  // shift chain, update filtered level on agreement
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1  <= 1'b0;
      s2  <= 1'b0;
      s3  <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        q_o <= s3;
    end
  end
endmodule // feih_sync

// *** feih_flag.v ***
// one sticky flag: set by an event, cleared by a write of one
// only while the cause is gone; set wins over clear
`timescale 1ns/1ps
module feih_flag
(
  input  wire clk_i,    // core clock
  input  wire rst_i,    // synchronous reset, active high
  input  wire set_i,    // event pulse or level
  input  wire cause_i,  // underlying condition still present
  input  wire clr_i,    // write of one to this flag
  output reg  flag_o    // sticky flag
);
  // set beats clear; clear refused while the cause persists
  always @(posedge clk_i)
  begin
    if (rst_i)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clr_i && !cause_i)
      flag_o <= 1'b0;
  end
endmodule // feih_flag

// *** feih_chk_checker.sv ***
// checker for the fault event handler ports: bus handshake,
// warm reset pulse shape and reset state; one clock domain
`timescale 1ns/1ps
module feih_chk
(
  input wire logic clk_i,                       // core clock
  input wire logic rst_i,                       // sync reset
  input wire logic cyc_i,                       // bus cycle
  input wire logic stb_i,                       // bus strobe
  input wire logic ack_o,                       // bus answer
  input wire logic driver_enable_output_o,      // driver enable
  input wire logic controller_reset_output_n_o, // reset out, low
  input wire logic processor_reset_output_n_o,  // reset out, low
  input wire logic interrupt_output_low_n_o     // interrupt, low
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a taken request is answered on the next edge
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  // answer lasts one cycle
  property p_ack_one; ack_o |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  // no answer without a request
  property p_ack_idle; !(cyc_i && stb_i) |=> !ack_o; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
  // both reset outputs move together in a warm reset
  property p_warm_pair;
    controller_reset_output_n_o == processor_reset_output_n_o;
  endproperty
  a_warm_pair: assert property (p_warm_pair) else $error("reset pair split");
  // drivers are off while a warm reset runs
  property p_warm_drv; !controller_reset_output_n_o |-> !driver_enable_output_o; endproperty
  a_warm_drv: assert property (p_warm_drv) else $error("driver on in reset");
  // warm reset pulse is not a glitch
  property p_warm_len;
    $fell(controller_reset_output_n_o) |-> !controller_reset_output_n_o [*8];
  endproperty
  a_warm_len: assert property (p_warm_len) else $error("warm reset short");
  // warm reset pulse lasts its full twenty cycles
  property p_warm_full;
    $fell(controller_reset_output_n_o) |-> ##19 !controller_reset_output_n_o;
  endproperty
  a_warm_full: assert property (p_warm_full) else $error("warm reset cut");
  // outputs leave reset idle
  property p_rst_idle;
    $fell(rst_i) |-> !ack_o && controller_reset_output_n_o && interrupt_output_low_n_o
      && !driver_enable_output_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bad reset state");
endmodule // feih_chk

// *** feih_host.sv ***
// host side pin model: error signal, readback pin, clock status
// and counters; assumes the bench picks which faults are present
`timescale 1ns/1ps
module feih_host
(
  input  wire logic       clk_i,     // core clock
  input  wire logic [2:0] fault_i,   // 0 readback, 1 monitor, 2 clock
  input  wire logic [3:0] wd_i,      // watchdog fail count wanted
  input  wire logic [3:0] rec_i,     // recovery count wanted
  output logic            proc_rb_o, // readback level, low is fault
  output logic            em_o,      // error signal, low is fault
  output logic            ckbad_o,   // switching clock bad
  output logic [3:0]      wd_o,      // watchdog fail count
  output logic [3:0]      rec_o      // recovery count
);
  // pins move just after an edge, like the real controller logic
  always @(posedge clk_i)
  begin
    proc_rb_o <= !fault_i[0];
    em_o      <= !fault_i[1];
    ckbad_o   <= fault_i[2];
    wd_o      <= wd_i;
    rec_o     <= rec_i;
  end
endmodule // feih_host

// *** tb.sv ***
// self-checking bench: bus tasks, flag model, host pin model
// assumes feih_top on one 10 mhz clock
`timescale 1ns/1ps
`include "feih_consts.vh"
module tb;
  localparam [7:0] FLG = `FEIH_FLAG_ADDR, MSK = `FEIH_MASK_ADDR, LIV = `FEIH_LIVE_ADDR,
    CFG = `FEIH_CFG_ADDR, DLY = `FEIH_DELAY_ADDR, WDL = `FEIH_WDLIM_ADDR, IRQ = `FEIH_IRQ_ADDR;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0; // bus drive
  logic [7:0]  adr = 0;                                        // bus address
  logic [31:0] wdat = 0, rdat, q;                              // bus data
  logic [2:0]  flt = 0;                                        // faults asked
  logic [3:0]  wd = 0, rec = 0;                                // counts asked
  logic [15:0] lfsr = 16'd54;                                  // random state
  wire         ack, pr, em, cb, drv, crn, prn, intn, irq;      // host pins and dut outputs
  wire  [3:0]  wdc, rc;                                        // counts to dut
  integer      error_cnt = 0, compares = 0, exp_f = 0, i;      // model flags
  initial forever #50 clk_i = ~clk_i;
  feih_host host_u (.clk_i, .fault_i(flt), .wd_i(wd), .rec_i(rec), .proc_rb_o(pr),
    .em_o(em), .ckbad_o(cb), .wd_o(wdc), .rec_o(rc));
  feih_top dut_u (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .proc_reset_readback_i(pr),
    .error_monitor_i(em), .ext_clk_bad_i(cb), .watchdog_fail_count_i(wdc),
    .recovery_count_i(rc), .driver_enable_output_o(drv), .controller_reset_output_n_o(crn),
    .processor_reset_output_n_o(prn), .interrupt_output_low_n_o(intn), .irq_o(irq));
  // closing report
  task wrap_up;
  begin
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
  begin
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  // one classic bus cycle, held until ack is seen
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
  begin
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    // ack and read data are taken as sampled at a rising edge
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      error_cnt++;
      wrap_up;
    end
    q = rdat;
    cyc <= 0;
    stb <= 0;
  end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
  begin
    wb(0, a, 0);
    chk(n, e, q);
  end
  endtask
  // write one to flags; model keeps bits whose cause persists
  task clr(input integer m, input integer c);
  begin
    wb(1, FLG, m);
    exp_f = exp_f & ~(m & ~c);
    rd(FLG, exp_f, "flags");
  end
  endtask
  // bounded wait for driver enable (s=0) or reset out (s=1)
  task wt(input integer s, input logic v);
    integer n;
  begin
    for (n = 0; n < 900 && (s ? crn : drv) !== v; n++) @(negedge clk_i);
    if (n == 900)
    begin
      error_cnt++;
      wrap_up;
    end
  end
  endtask
  function automatic logic [15:0] nx(input logic [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    rd(CFG, 32'h2, "cfg");
    rd(DLY, 32'h0a0a, "delays");
    rd(WDL, 32'h73, "wd limits");
    rd(MSK, 0, "mask");
    wb(1, 8'hfc, 32'hffffffff);
    rd(8'hfc, 0, "unmapped");
    for (i = 0; i < 4; i++)
    begin
      lfsr = nx(lfsr);
      wb(1, DLY, {16'h0, lfsr});
      rd(DLY, {16'h0, lfsr}, "delay rnd");
    end
    wb(1, DLY, 32'h0202);
    $display("registers done");
    rd(IRQ, 0, "irq idle");
    flt <= 3'b001;
    exp_f = 1;
    repeat (8) @(posedge clk_i);
    rd(FLG, exp_f, "readback flag");
    rd(LIV, 1, "readback live");
    @(negedge clk_i);
    chk("int low", 0, intn);
    chk("irq", 1, irq);
    rd(IRQ, 1, "irq stat");
    rd(IRQ, 0, "irq read clear");
    wb(1, MSK, 1);
    @(negedge clk_i);
    chk("int masked", 1, intn);
    wb(1, MSK, 0);
    clr(1, 1);
    flt <= 0;
    repeat (8) @(posedge clk_i);
    clr(1, 0);
    @(negedge clk_i);
    chk("int off", 1, intn);
    $display("readback done");
    wb(1, CFG, 32'ha);
    flt <= 3'b100;
    exp_f = 16;
    repeat (8) @(posedge clk_i);
    rd(LIV, 16, "clock live");
    wb(1, `FEIH_IRQMASK_ADDR, 16);
    @(negedge clk_i);
    chk("irq masked", 0, irq);
    wb(1, `FEIH_IRQMASK_ADDR, 0);
    rd(IRQ, 16, "irq clock");
    clr(16, 16);
    flt <= 0;
    repeat (8) @(posedge clk_i);
    clr(16, 0);
    $display("clock done");
    flt <= 3'b010;
    exp_f = 2;
    wt(0, 0);
    exp_f = 6;
    clr(6, 6);
    wt(1, 0);
    chk("drv warm", 0, drv);
    rd(FLG, exp_f, "monitor hidden");
    flt <= 0;
    wt(1, 1);
    exp_f = 14;
    repeat (4) @(posedge clk_i);
    rd(FLG, exp_f, "monitor flags");
    clr(14, 0);
    $display("monitor done");
    wb(1, CFG, 32'h6);
    wd <= 4;
    exp_f = 32;
    wt(0, 0);
    wb(1, MSK, 32'h7f);
    @(negedge clk_i);
    chk("int wd", 0, intn);
    wd <= 8;
    wt(1, 0);
    wd <= 0;
    wt(1, 1);
    exp_f = 96;
    repeat (4) @(posedge clk_i);
    rd(FLG, exp_f, "wd flags");
    rec <= 3;
    repeat (4) @(posedge clk_i);
    rd(FLG, 32, "wd hidden");
    rec <= 0;
    repeat (4) @(posedge clk_i);
    clr(96, 0);
    wt(0, 1);
    $display("watchdog done");
    wrap_up;
  end
endmodule // tb
bind feih_top feih_chk chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .driver_enable_output_o,
  .controller_reset_output_n_o, .processor_reset_output_n_o, .interrupt_output_low_n_o);
